//--- gpm_apb_regs.sv
`timescale 1ns/1ns
`include "gpm_defs.svh"
module gpm_apb_regs #(
    parameter int ADDR_W = 12
) (
    // Clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // APB slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    // Control toward the mux
    gpm_cfg_if.regs                cfg
);

    gpm_pkg::gpm_reg_state_type state;
    gpm_pkg::gpm_reg_state_type next_state;
    logic                       hit_ctrl;
    logic                       hit_stat;
    logic                       ctrl_write;

    // Word address match against a register index
    function automatic logic addr_hit(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
        addr_hit = (a[ADDR_W-1:2] == {{(ADDR_W-10){1'b0}}, idx});
    endfunction

    assign hit_ctrl   = addr_hit(paddr, `GPM_CTRL_IDX);
    assign hit_stat   = addr_hit(paddr, `GPM_STAT_IDX);
    assign ctrl_write = psel && penable && pwrite && hit_ctrl && pstrb[`GPM_STRB_LANE];

    // Zero wait states; read data is staged in the setup cycle
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !(hit_ctrl || hit_stat);
    assign prdata  = state.rdata;
    assign cfg.ctrl = state.ctrl;

    // Next state
    always_comb begin
        next_state = state;
        if (ctrl_write) begin
            next_state.ctrl = pwdata[7:0];
        end
        if (psel && !penable) begin
            next_state.rdata = 32'h0000_0000;
            if (hit_ctrl) begin
                next_state.rdata = {24'h00_0000, state.ctrl};
            end else if (hit_stat) begin
                next_state.rdata = {29'h0000_0000, cfg.reserved_code,
                                    cfg.pin_drive, cfg.pin_level};
            end
        end
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= {`GPM_CTRL_RESET, 32'h0000_0000};
        end else begin
            state <= next_state;
        end
    end

    property p_ctrl_reset;
        @(posedge pclk) !presetn |-> (state.ctrl == `GPM_CTRL_RESET);
    endproperty
    a_ctrl_reset: assert property (p_ctrl_reset) else $error("control not cleared in reset");

    property p_ctrl_store;
        @(posedge pclk) disable iff (!presetn)
        ctrl_write |=> (cfg.ctrl == $past(pwdata[7:0]));
    endproperty
    a_ctrl_store: assert property (p_ctrl_store) else $error("control write lost");

endmodule

//--- gpm_board_monitor.sv
`timescale 1ns/1ns
module gpm_board_monitor (
    // Pin driver from the device
    input  wire logic pin_out,
    input  wire logic pin_oe,
    // Level that board logic sees
    output logic      board_level
);
    // pin undriven when disabled
    // Board pull-down decides the level, so a floating pin never reads as the last value
    assign board_level = pin_oe ? pin_out : 1'b0;
endmodule

//--- gpm_cfg_if.sv
`timescale 1ns/1ns
interface gpm_cfg_if;
    gpm_pkg::gpm_ctrl_type ctrl;
    logic                  pin_level;
    logic                  pin_drive;
    logic                  reserved_code;

    // Register side owns the control byte
    modport regs (
        output ctrl,
        input  pin_level,
        input  pin_drive,
        input  reserved_code
    );

    // Mux side reports the pin back
    modport mux (
        input  ctrl,
        output pin_level,
        output pin_drive,
        output reserved_code
    );
endinterface

//--- gpm_defs.svh
`ifndef GPM_DEFS_SVH
`define GPM_DEFS_SVH

// Register indices; byte address is four times the index
`define GPM_CTRL_IDX      8'h13
`define GPM_STAT_IDX      8'h40
`define GPM_CTRL_RESET    8'h00
`define GPM_STRB_LANE     0

// Source class codes
`define GPM_SRC_DEV       3'h4
`define GPM_SRC_RSVD      3'h5
`define GPM_SRC_TX0       3'h6
`define GPM_SRC_TX1       3'h7

// Selections for a receive-link source
`define GPM_LSEL_RPIN3    3'h3
`define GPM_LSEL_LOCK     3'h4
`define GPM_LSEL_PASS     3'h5
`define GPM_LSEL_FV       3'h6
`define GPM_LSEL_LV       3'h7

// Selections for the device-status source
`define GPM_DSEL_VAL      3'h0
`define GPM_DSEL_LOCK_OR  3'h1
`define GPM_DSEL_LOCK_AND 3'h2
`define GPM_DSEL_PASS_AND 3'h3
`define GPM_DSEL_FSYNC    3'h4

// Selections for a transmit-port source
`define GPM_TSEL_AND      3'h0
`define GPM_TSEL_OR       3'h1
`define GPM_TSEL_FV       3'h2
`define GPM_TSEL_LV       3'h3
`define GPM_TSEL_SYNC     3'h4
`define GPM_TSEL_IRQ      3'h5

`endif

//--- gpm_pin_mux.sv
`timescale 1ns/1ns
`include "gpm_defs.svh"
module gpm_pin_mux #(
    parameter int ADDR_W = 12,
    parameter int LINKS  = 4,
    parameter int PORTS  = 2
) (
    // Clock and reset
    input  wire logic                        pclk,
    input  wire logic                        presetn,
    // APB slave
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [ADDR_W-1:0]           paddr,
    input  wire logic [31:0]                 pwdata,
    input  wire logic [3:0]                  pstrb,
    output logic [31:0]                      prdata,
    output logic                             pready,
    output logic                             pslverr,
    // Receive link status, core clock domain
    input  wire logic [LINKS-1:0][3:0]       link_remote_pin,
    input  wire logic [LINKS-1:0]            link_lock,
    input  wire logic [LINKS-1:0]            link_pass,
    input  wire logic [LINKS-1:0]            link_frame_valid,
    input  wire logic [LINKS-1:0]            link_line_valid,
    input  wire logic [LINKS-1:0]            link_enable,
    // Device status
    input  wire logic                        frame_sync_pulse,
    // Transmit port status
    input  wire logic [PORTS-1:0][LINKS-1:0] tx_link_map,
    input  wire logic [PORTS-1:0]            tx_frame_valid,
    input  wire logic [PORTS-1:0]            tx_line_valid,
    input  wire logic [PORTS-1:0]            tx_synced,
    input  wire logic [PORTS-1:0]            tx_interrupt,
    // Pin driver
    output logic                             pin_out,
    output logic                             pin_oe
);

    gpm_cfg_if cfg ();

    gpm_pkg::gpm_pin_state_type state;
    gpm_pkg::gpm_pin_state_type next_state;
    logic [LINKS-1:0]           link_pick;
    logic [LINKS-1:0]           link_pick_rsvd;
    logic [PORTS-1:0]           port_pick;
    logic [PORTS-1:0]           port_pick_rsvd;
    logic                       dev_pick;
    logic                       dev_pick_rsvd;
    logic [2:0]                 sel;
    logic [2:0]                 src;

    assign sel = cfg.ctrl.pin_signal_select;
    assign src = cfg.ctrl.pin_source_class;

    // Register slave
    gpm_apb_regs #(
        .ADDR_W (ADDR_W)
    ) u_regs (
        .pclk    (pclk),
        .presetn (presetn),
        .psel    (psel),
        .penable (penable),
        .pwrite  (pwrite),
        .paddr   (paddr),
        .pwdata  (pwdata),
        .pstrb   (pstrb),
        .prdata  (prdata),
        .pready  (pready),
        .pslverr (pslverr),
        .cfg     (cfg.regs)
    );

    // Signal of one receive link for a select code
    function automatic logic link_sig(
        input logic [2:0] s,
        input logic [3:0] rpin,
        input logic       lock,
        input logic       pass,
        input logic       fv,
        input logic       lv
    );
        link_sig = 1'b0;
        unique case (s)
            `GPM_LSEL_LOCK: link_sig = lock;
            `GPM_LSEL_PASS: link_sig = pass;
            `GPM_LSEL_FV:   link_sig = fv;
            `GPM_LSEL_LV:   link_sig = lv;
            default:        link_sig = rpin[s[1:0]];
        endcase
    endfunction

    // Signal of one transmit port; the second flag marks a reserved code
    function automatic logic [1:0] port_sig(
        input logic [2:0]       s,
        input logic [LINKS-1:0] map,
        input logic             fv,
        input logic             lv,
        input logic             synced,
        input logic             irq
    );
        port_sig = 2'h1;
        unique case (s)
            `GPM_TSEL_AND:  port_sig = {&(link_pass | ~map), 1'b0};
            `GPM_TSEL_OR:   port_sig = {|(link_pass & map), 1'b0};
            `GPM_TSEL_FV:   port_sig = {fv, 1'b0};
            `GPM_TSEL_LV:   port_sig = {lv, 1'b0};
            `GPM_TSEL_SYNC: port_sig = {synced, 1'b0};
            `GPM_TSEL_IRQ:  port_sig = {irq, 1'b0};
            default:        port_sig = 2'h1;
        endcase
    endfunction

    // Per-link candidates; every link select code is meaningful
    genvar gl;
    generate
        for (gl = 0; gl < LINKS; gl++) begin : g_link
            assign link_pick[gl] = link_sig(sel, link_remote_pin[gl], link_lock[gl],
                                            link_pass[gl], link_frame_valid[gl],
                                            link_line_valid[gl]);
            assign link_pick_rsvd[gl] = 1'b0;
        end
    endgenerate

    // Per-port candidates; only that port's links count
    genvar gp;
    generate
        for (gp = 0; gp < PORTS; gp++) begin : g_port
            assign {port_pick[gp], port_pick_rsvd[gp]} =
                port_sig(sel, tx_link_map[gp], tx_frame_valid[gp], tx_line_valid[gp],
                         tx_synced[gp], tx_interrupt[gp]);
        end
    endgenerate

    // Device-wide status candidates
    always_comb begin
        dev_pick      = 1'b0;
        dev_pick_rsvd = 1'b0;
        unique case (sel)
            `GPM_DSEL_VAL:      dev_pick = cfg.ctrl.pin_software_value;
            `GPM_DSEL_LOCK_OR:  dev_pick = |(link_lock & link_enable);
            `GPM_DSEL_LOCK_AND: dev_pick = &(link_lock | ~link_enable);
            `GPM_DSEL_PASS_AND: dev_pick = &(link_pass | ~link_enable);
            `GPM_DSEL_FSYNC:    dev_pick = frame_sync_pulse;
            default:            dev_pick_rsvd = 1'b1;
        endcase
    end

    // Next pin state
    always_comb begin
        next_state = state;
        next_state.reserved_code = 1'b0;
        next_state.pin_level     = 1'b0;
        if (!src[2]) begin
            next_state.pin_level     = link_pick[src[1:0]];
            next_state.reserved_code = link_pick_rsvd[src[1:0]];
        end else if (src == `GPM_SRC_DEV) begin
            next_state.pin_level     = dev_pick;
            next_state.reserved_code = dev_pick_rsvd;
        end else if (src == `GPM_SRC_RSVD) begin
            next_state.reserved_code = 1'b1;
        end else begin
            next_state.pin_level     = port_pick[src[0]];
            next_state.reserved_code = port_pick_rsvd[src[0]];
        end
        if (next_state.reserved_code) begin
            next_state.pin_level = 1'b0;
        end
        next_state.pin_drive = cfg.ctrl.pin_drive_enable;
        if (!cfg.ctrl.pin_drive_enable) begin
            next_state.pin_level = 1'b0;  // Quiet level while released
        end
    end

    // Pin register; one cycle of latency keeps the pin glitch free
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= 3'h0;
        end else begin
            state <= next_state;
        end
    end

    assign pin_out           = state.pin_level;
    assign pin_oe            = state.pin_drive;
    assign cfg.pin_level     = state.pin_level;
    assign cfg.pin_drive     = state.pin_drive;
    assign cfg.reserved_code = state.reserved_code;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_on_link;
        cfg.ctrl.pin_drive_enable && !src[2];
    endsequence

    sequence s_on_dev;
        cfg.ctrl.pin_drive_enable && (src == `GPM_SRC_DEV);
    endsequence

    sequence s_on_port;
        cfg.ctrl.pin_drive_enable && (src[2:1] == 2'h3);
    endsequence

    property p_off;
        !cfg.ctrl.pin_drive_enable |=> !pin_oe && !pin_out;
    endproperty
    a_off: assert property (p_off) else $error("pin driven while disabled");

    property p_on;
        cfg.ctrl.pin_drive_enable |=> pin_oe;
    endproperty
    a_on: assert property (p_on) else $error("pin not driven while enabled");

    property p_link_rpin;
        s_on_link ##0 (sel <= `GPM_LSEL_RPIN3)
        |=> pin_out == $past(link_remote_pin[src[1:0]][sel[1:0]]);
    endproperty
    a_link_rpin: assert property (p_link_rpin) else $error("remote pin not forwarded");

    property p_link_lock;
        s_on_link ##0 (sel == `GPM_LSEL_LOCK) |=> pin_out == $past(link_lock[src[1:0]]);
    endproperty
    a_link_lock: assert property (p_link_lock) else $error("link lock not shown");

    property p_link_lv;
        s_on_link ##0 (sel == `GPM_LSEL_LV) |=> pin_out == $past(link_line_valid[src[1:0]]);
    endproperty
    a_link_lv: assert property (p_link_lv) else $error("link line valid not shown");

    property p_dev_val;
        s_on_dev ##0 (sel == `GPM_DSEL_VAL)
        |=> pin_out == $past(cfg.ctrl.pin_software_value);
    endproperty
    a_dev_val: assert property (p_dev_val) else $error("software value not on pin");

    property p_dev_lock_or;
        s_on_dev ##0 (sel == `GPM_DSEL_LOCK_OR)
        |=> pin_out == $past(|(link_lock & link_enable));
    endproperty
    a_dev_lock_or: assert property (p_dev_lock_or) else $error("lock OR wrong");

    property p_dev_pass_and;
        s_on_dev ##0 (sel == `GPM_DSEL_PASS_AND)
        |=> pin_out == $past(&(link_pass | ~link_enable));
    endproperty
    a_dev_pass_and: assert property (p_dev_pass_and) else $error("pass AND wrong");

    property p_port_fv;
        s_on_port ##0 (sel == `GPM_TSEL_FV) |=> pin_out == $past(tx_frame_valid[src[0]]);
    endproperty
    a_port_fv: assert property (p_port_fv) else $error("port frame valid wrong");

    property p_port_or;
        s_on_port ##0 (sel == `GPM_TSEL_OR)
        |=> pin_out == $past(|(link_pass & tx_link_map[src[0]]));
    endproperty
    a_port_or: assert property (p_port_or) else $error("port pass OR wrong");

    property p_port_irq;
        s_on_port ##0 (sel == `GPM_TSEL_IRQ) |=> pin_out == $past(tx_interrupt[src[0]]);
    endproperty
    a_port_irq: assert property (p_port_irq) else $error("port interrupt wrong");

    property p_rsvd_low;
        (src == `GPM_SRC_RSVD) [*2] |-> !pin_out && (pin_oe == $past(cfg.ctrl.pin_drive_enable));
    endproperty
    a_rsvd_low: assert property (p_rsvd_low) else $error("reserved source not low");

    property p_rsvd_sel;
        s_on_port ##0 (sel > `GPM_TSEL_IRQ) |=> !pin_out && pin_oe;
    endproperty
    a_rsvd_sel: assert property (p_rsvd_sel) else $error("reserved select not low");

endmodule

//--- gpm_pkg.sv
package gpm_pkg;

    // Control register layout
    typedef struct packed {
        logic [2:0] pin_signal_select;
        logic [2:0] pin_source_class;
        logic       pin_software_value;
        logic       pin_drive_enable;
    } gpm_ctrl_type;

    // Pin driver state
    typedef struct packed {
        logic pin_level;
        logic pin_drive;
        logic reserved_code;
    } gpm_pin_state_type;

    // Register slave state
    typedef struct packed {
        gpm_ctrl_type ctrl;
        logic [31:0]  rdata;
    } gpm_reg_state_type;

endpackage

//--- gpm_tb.sv
`timescale 1ns/1ns
module tb;
    // Bus side
    logic            pclk = 1'b0;
    logic            presetn;
    logic            psel = 1'b0;
    logic            penable = 1'b0;
    logic            pwrite = 1'b0;
    logic [11:0]     paddr = 12'h000;
    logic [31:0]     pwdata = 32'h0;
    logic [3:0]      pstrb = 4'hF;
    logic [31:0]     prdata;
    logic            pready;
    logic            pslverr;
    // Status sources
    logic [3:0][3:0] rpin = 16'h0;
    logic [3:0]      lock = 4'h0, pass = 4'h0, fv = 4'h0, lv = 4'h0, en = 4'h0;
    logic            fsync = 1'b0;
    logic [1:0][3:0] map = 8'h0;
    logic [1:0]      tfv = 2'h0, tlv = 2'h0, tsync = 2'h0, tirq = 2'h0;
    logic            pin_out, pin_oe, board_level;
    logic [31:0]     rd;
    logic            err;
    int              errors = 0, checks = 0, cycles = 0;

    gpm_pin_mux #(.ADDR_W(12), .LINKS(4), .PORTS(2)) dut_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .link_remote_pin(rpin), .link_lock(lock), .link_pass(pass),
        .link_frame_valid(fv), .link_line_valid(lv), .link_enable(en),
        .frame_sync_pulse(fsync), .tx_link_map(map), .tx_frame_valid(tfv),
        .tx_line_valid(tlv), .tx_synced(tsync), .tx_interrupt(tirq),
        .pin_out(pin_out), .pin_oe(pin_oe));

    gpm_board_monitor mon_u (.pin_out(pin_out), .pin_oe(pin_oe), .board_level(board_level));

    // Clock, 100 ns period
    always #50 pclk = ~pclk;

    // Hang guard, far above the few hundred cycles the tests use
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errors++;
            close_out();
        end
    end

    task automatic close_out;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("unexpected %s: expected %h seen %h", name, exp, got);
        end
    endtask

    // One APB transfer; request held until pready is seen high
    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] d);
        apb(12'h04C, 1'b1, {24'h0, d});
    endtask

    // Pin settles one edge after its inputs are sampled
    task automatic pin(input logic eo, input logic ev);
        repeat (2) @(posedge pclk);
        #1;
        chk("pin_oe", {31'h0, eo}, {31'h0, pin_oe});
        chk("pin_out", {31'h0, ev}, {31'h0, pin_out});
        chk("board_level", {31'h0, ev}, {31'h0, board_level});
    endtask

    task automatic t_bus;
        apb(12'h04C, 1'b0, 32'h0);
        chk("ctrl reset", 32'h0, rd);
        chk("oe reset", 32'h0, {31'h0, pin_oe});
        chk("pready", 32'h1, {31'h0, pready});
        @(posedge pclk);
        pstrb <= 4'h0;
        wr(8'hFF);
        pstrb <= 4'hF;
        apb(12'h04C, 1'b0, 32'h0);
        chk("ctrl no strobe", 32'h0, rd);
        apb(12'h200, 1'b1, 32'h0000_00FF);
        chk("unmapped error", 32'h1, {31'h0, err});
        apb(12'h200, 1'b0, 32'h0);
        chk("unmapped data", 32'h0, rd);
        wr(8'h13);
        #1;
        chk("oe before", 32'h0, {31'h0, pin_oe});
        @(posedge pclk);
        #1;
        chk("oe after", 32'h1, {31'h0, pin_oe});
        chk("out value", 32'h1, {31'h0, pin_out});
        apb(12'h04C, 1'b0, 32'h0);
        chk("ctrl readback", 32'h13, rd);
        apb(12'h100, 1'b0, 32'h0);
        chk("status", 32'h3, rd);
        wr(8'h12);
        pin(1'b0, 1'b0);
        $display("test bus done");
    endtask

    task automatic t_links;
        logic [3:0][3:0] r;
        logic [3:0]      k, p, f, l;
        for (int v = 0; v < 2; v++)
            for (int src = 0; src < 4; src++)
                for (int s = 0; s < 8; s++) begin
                    r = v ? 16'h0000 : 16'hFFFF;
                    k = v ? 4'h0 : 4'hF;
                    p = k;
                    f = k;
                    l = k;
                    case (s)
                        4: k[src] = v[0];
                        5: p[src] = v[0];
                        6: f[src] = v[0];
                        7: l[src] = v[0];
                        default: r[src][s] = v[0];
                    endcase
                    wr({s[2:0], src[2:0], 2'h1});
                    @(posedge pclk);
                    rpin <= r;
                    lock <= k;
                    pass <= p;
                    fv <= f;
                    lv <= l;
                    pin(1'b1, v[0]);
                end
        $display("test links done");
    endtask

    task automatic dcase(input logic [2:0] s, input logic vb, input logic [3:0] e,
                         input logic [3:0] k, input logic [3:0] p, input logic ev);
        wr({s, 3'h4, vb, 1'b1});
        @(posedge pclk);
        en <= e;
        lock <= k;
        pass <= p;
        pin(1'b1, ev);
    endtask

    task automatic t_device;
        dcase(3'h0, 1'b1, 4'h0, 4'h0, 4'h0, 1'b1);
        dcase(3'h0, 1'b0, 4'hF, 4'hF, 4'hF, 1'b0);
        dcase(3'h1, 1'b0, 4'h5, 4'hA, 4'h0, 1'b0);
        dcase(3'h1, 1'b0, 4'h5, 4'h4, 4'h0, 1'b1);
        dcase(3'h2, 1'b0, 4'h5, 4'h7, 4'h0, 1'b1);
        dcase(3'h2, 1'b0, 4'h5, 4'h3, 4'h0, 1'b0);
        dcase(3'h3, 1'b0, 4'h5, 4'h0, 4'h5, 1'b1);
        dcase(3'h3, 1'b0, 4'h5, 4'hF, 4'hB, 1'b0);
        @(posedge pclk);
        fsync <= 1'b1;
        dcase(3'h4, 1'b0, 4'h0, 4'h0, 4'h0, 1'b1);
        for (int s = 5; s < 8; s++)
            dcase(s[2:0], 1'b1, 4'hF, 4'hF, 4'hF, 1'b0);
        wr(8'h17);
        pin(1'b1, 1'b0);
        apb(12'h100, 1'b0, 32'h0);
        chk("status reserved", 32'h6, rd);
        @(posedge pclk);
        fsync <= 1'b0;
        dcase(3'h4, 1'b1, 4'h0, 4'h0, 4'h0, 1'b0);
        $display("test device done");
    endtask

    task automatic pcase(input int p, input logic [2:0] s, input logic [3:0] ps,
                         input logic v, input logic ev);
        logic [1:0] t;
        t = v ? 2'h1 << p : ~(2'h1 << p);
        wr({s, 3'h6 + p[2:0], 2'h1});
        @(posedge pclk);
        map[p] <= 4'h6;
        map[1-p] <= 4'h9;
        pass <= ps;
        tfv <= (s == 3'h2) ? t : ~t;
        tlv <= (s == 3'h3) ? t : ~t;
        tsync <= (s == 3'h4) ? t : ~t;
        tirq <= (s == 3'h5) ? t : ~t;
        pin(1'b1, ev);
    endtask

    task automatic t_ports;
        for (int p = 0; p < 2; p++) begin
            pcase(p, 3'h0, 4'h6, 1'b0, 1'b1);
            pcase(p, 3'h0, 4'h2, 1'b0, 1'b0);
            pcase(p, 3'h1, 4'h2, 1'b0, 1'b1);
            pcase(p, 3'h1, 4'h9, 1'b0, 1'b0);
            for (int s = 2; s < 6; s++) begin
                pcase(p, s[2:0], 4'h0, 1'b1, 1'b1);
                pcase(p, s[2:0], 4'h0, 1'b0, 1'b0);
            end
            for (int s = 6; s < 8; s++)
                pcase(p, s[2:0], 4'hF, 1'b0, 1'b0);
        end
        $display("test ports done");
    endtask

    // Main sequence
    initial begin
        // Fall from unknown at time zero, so reset is in force before the first edge
        presetn <= 1'b0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        t_bus();
        t_links();
        t_device();
        t_ports();
        close_out();
    end
endmodule
